// ==== logic/sspc_top.sv ====
// sync source selection, separator, pll hold and status registers
`timescale 1ns/1ps
`include "sspc_consts.svh"
module sspc_top
  import sspc_pkg::*;
#(
  parameter int unsigned ACT_WIN_CYC = `SSPC_ACT_WIN_CYC
)
(
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // sync pins from the video source
  input  wire logic       hsync_pin_i,
  input  wire logic       vsync_pin_i,
  input  wire logic       green_embedded_sync_input_i,
  input  wire logic       hold_pin_i,
  // register port from the serial control slave
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  output logic      [7:0] reg_rdata_o,
  // pll side
  output logic            pll_hsync_o,
  output logic            pll_hold_o,
  output logic            sep_vsync_o,
  // analog front end controls
  output logic      [4:0] slicer_code_o,
  output logic      [2:0] clamp_mid_o,
  output logic            full_power_off_control_o,
  output logic            seek_mode_o,
  // resolved sources
  output logic            active_horizontal_source_o,
  output logic            active_vertical_source_o
);

  // decode of a register port address, used for write and read
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ofs);
    is_addr = (a == ofs);
  endfunction : is_addr

  // pin watchers
  sspc_watch_t hs_w;            // horizontal sync pin
  sspc_watch_t vs_w;            // vertical sync pin
  sspc_watch_t gs_w;            // sync on green slicer output
  sspc_watch_t hold_w;          // hold pin

  // configuration registers
  sspc_mode_t  mode_reg;
  sspc_mode_t  mode_next;
  sspc_hold_t  hold_reg;
  sspc_hold_t  hold_next;
  sspc_slice_t slice_reg;
  sspc_slice_t slice_next;
  logic [7:0]  sep_thr_reg;     // separator count threshold
  logic [7:0]  sep_thr_next;
  logic [7:0]  lead_reg;        // pre-hold lines
  logic [7:0]  lead_next;
  logic [7:0]  trail_reg;       // post-hold lines
  logic [7:0]  trail_next;
  logic [7:0]  rdata_next;

  // separator and timing state
  logic [3:0]  div_reg;         // 5 MHz tick divider
  logic [3:0]  div_next;
  logic        tick;            // one-cycle separator enable
  logic [7:0]  sep_cnt_reg;     // ticks since input differed from output
  logic [7:0]  sep_cnt_next;
  logic        sep_reg;         // separated vertical sync, active high
  logic        sep_next;
  logic        hs_prev_reg;     // last normalised hsync
  logic        vs_prev_reg;     // last normalised vsync
  logic [11:0] line_reg;        // lines since vsync start
  logic [11:0] line_next;
  logic [11:0] total_reg;       // lines in the previous frame
  logic [11:0] total_next;
  logic [7:0]  post_reg;        // post-hold lines left
  logic [7:0]  post_next;

  // resolved signals
  logic        active_horizontal_source; // 1 = green sync drives the pll
  logic        active_vertical_source;   // 1 = separator output is vsync
  logic        hs_norm;         // chosen hsync, active high
  logic        vs_norm;         // chosen vsync, active high
  logic        vs_out_pol;      // polarity of the chosen vsync
  logic        hs_lead;         // leading edge of chosen hsync
  logic        vs_lead;
  logic        vs_trail;
  logic        hold_src;        // raw level of the hold source
  logic        hold_pol_eff;    // level that means hold
  logic        pre_on;
  logic        hold_now;
  sspc_stat_t  stat;

  // outputs
  logic        pll_hs_next;
  logic        pll_hold_next;
  logic        seek_next;

  // watchers on every pin that enters the clock domain
  sspc_sync_watch #(.WIN_CYC(ACT_WIN_CYC)) u_hs_watch
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (hsync_pin_i),
    .watch_o (hs_w)
  );
  sspc_sync_watch #(.WIN_CYC(ACT_WIN_CYC)) u_vs_watch
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (vsync_pin_i),
    .watch_o (vs_w)
  );
  sspc_sync_watch #(.WIN_CYC(ACT_WIN_CYC)) u_gs_watch
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (green_embedded_sync_input_i),
    .watch_o (gs_w)
  );
  sspc_sync_watch #(.WIN_CYC(ACT_WIN_CYC)) u_hold_watch
  (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .pin_i   (hold_pin_i),
    .watch_o (hold_w)
  );

  // source resolution and status word
  always_comb
  begin
    // horizontal: override or a tie follows the select bit
    if (mode_reg.hsrc_ovr || (hs_w.active == gs_w.active))               // [R14] [R18]
      active_horizontal_source = mode_reg.hsrc_sel;
    else
      active_horizontal_source = gs_w.active;                            // [R14]
    // vertical: override picks, else pin when active
    active_vertical_source = mode_reg.vsrc_ovr ? mode_reg.vsrc_sel : !vs_w.active; // [R17] [R19]
    hs_norm    = active_horizontal_source ? (gs_w.level ~^ gs_w.polarity)
                                          : (hs_w.level ~^ hs_w.polarity);
    vs_norm    = active_vertical_source ? sep_reg : (vs_w.level ~^ vs_w.polarity);
    vs_out_pol = active_vertical_source ? 1'b1 : vs_w.polarity;
    hs_lead    = hs_norm && !hs_prev_reg;
    vs_lead    = vs_norm && !vs_prev_reg;
    vs_trail   = !vs_norm && vs_prev_reg;
    stat.hs_det                   = hs_w.active;                         // [R13]
    stat.active_horizontal_source = active_horizontal_source;            // [R14]
    stat.hs_pol                   = hs_w.polarity;                       // [R15]
    stat.vs_det                   = vs_w.active;                         // [R16]
    stat.active_vertical_source   = active_vertical_source;              // [R17]
    stat.vs_out_pol               = vs_out_pol;
    stat.gs_det                   = gs_w.active;
    stat.hold_pol                 = hold_w.polarity;
  end

  // register writes; the status offset has no storage behind it
  always_comb
  begin
    mode_next    = mode_reg;
    hold_next    = hold_reg;
    slice_next   = slice_reg;
    sep_thr_next = sep_thr_reg;
    lead_next    = lead_reg;
    trail_next   = trail_reg;
    if (reg_wr_i)
    begin
      if (is_addr(reg_addr_i, `SSPC_MODE_OFS))
        mode_next = sspc_mode_t'(reg_wdata_i);                           // [R18] [R19]
      if (is_addr(reg_addr_i, `SSPC_HOLD_OFS))
        hold_next = sspc_hold_t'(reg_wdata_i);
      if (is_addr(reg_addr_i, `SSPC_SLICE_OFS))
        slice_next = sspc_slice_t'(reg_wdata_i);                         // [R07] [R08]
      if (is_addr(reg_addr_i, `SSPC_SEP_OFS))
        sep_thr_next = reg_wdata_i;
      if (is_addr(reg_addr_i, `SSPC_LEAD_OFS))
        lead_next = reg_wdata_i;
      if (is_addr(reg_addr_i, `SSPC_TRAIL_OFS))
        trail_next = reg_wdata_i;
    end
    // reads: registered, unmapped addresses answer zero
    rdata_next = 8'h00;
    if (is_addr(reg_addr_i, `SSPC_MODE_OFS))
      rdata_next = mode_reg;
    else if (is_addr(reg_addr_i, `SSPC_HOLD_OFS))
      rdata_next = hold_reg;
    else if (is_addr(reg_addr_i, `SSPC_SLICE_OFS))
      rdata_next = slice_reg;
    else if (is_addr(reg_addr_i, `SSPC_SEP_OFS))
      rdata_next = sep_thr_reg;
    else if (is_addr(reg_addr_i, `SSPC_LEAD_OFS))
      rdata_next = lead_reg;
    else if (is_addr(reg_addr_i, `SSPC_TRAIL_OFS))
      rdata_next = trail_reg;
    else if (is_addr(reg_addr_i, `SSPC_STAT_OFS))
      rdata_next = stat;                                                 // [R20]
  end

  // separator: output follows the input only after it has differed
  // for more than threshold ticks, so short hsync pulses never get through
  always_comb
  begin
    tick         = (div_reg == 4'(`SSPC_SEP_DIV - 1));
    div_next     = tick ? 4'h0 : div_reg + 4'h1;
    sep_cnt_next = sep_cnt_reg;
    sep_next     = sep_reg;
    if (hs_norm == sep_reg)
    begin
      sep_cnt_next = 8'h00;
    end
    else if (tick)
    begin
      if (sep_cnt_reg >= sep_thr_reg)                                    // [R09] [R10]
      begin
        sep_next     = hs_norm;
        sep_cnt_next = 8'h00;
      end
      else
      begin
        sep_cnt_next = sep_cnt_reg + 8'h01;                              // [R09]
      end
    end
  end

  // line counting for pre-hold and post-hold
  always_comb
  begin
    line_next  = line_reg;
    total_next = total_reg;
    post_next  = post_reg;
    if (vs_lead)
    begin
      // learn frame length so the next frame can open hold early
      total_next = line_reg;
      line_next  = 12'h000;
    end
    else if (hs_lead && !(&line_reg))
    begin
      line_next = line_reg + 12'h001;
    end
    if (vs_trail)
    begin
      post_next = trail_reg;                                             // [R12]
    end
    else if (hs_lead && (post_reg != 8'h00))
    begin
      post_next = post_reg - 8'h01;                                      // [R12]
    end
    // first frame after reset has no length yet, so no pre-hold
    pre_on = (lead_reg != 8'h00) && (total_reg > {4'h0, lead_reg})
             && (line_reg >= total_reg - {4'h0, lead_reg});              // [R11]
  end

  // hold source, polarity and pll gating
  always_comb
  begin
    hold_src = hold_reg.hold_from_vs ? vs_norm : hold_w.level;           // [R01]
    if (hold_reg.hold_pol_ovr)
    begin
      hold_pol_eff = hold_reg.hold_pol;                                  // [R02] [R03]
    end
    else
    begin
      hold_pol_eff = hold_reg.hold_from_vs ? 1'b1 : hold_w.polarity;     // [R02]
    end
    hold_now      = (hold_src == hold_pol_eff) || pre_on
                    || (post_reg != 8'h00);                              // [R04] [R11] [R12]
    pll_hold_next = hold_now;
    // while holding, the pll sees no hsync and free-runs
    pll_hs_next   = hs_norm && !hold_now;                                // [R04]
    seek_next     = hold_reg.seek_allow && hold_reg.power_on
                    && !hs_w.active && !vs_w.active && !gs_w.active;     // [R05]
  end

  // register stage for all state above
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_reg      <= sspc_mode_t'(`SSPC_MODE_RST);
      hold_reg      <= sspc_hold_t'(`SSPC_HOLD_RST);
      slice_reg     <= sspc_slice_t'(`SSPC_SLICE_RST);
      sep_thr_reg   <= `SSPC_SEP_RST;
      lead_reg      <= `SSPC_LEAD_RST;
      trail_reg     <= `SSPC_TRAIL_RST;
      reg_rdata_o   <= 8'h00;
      div_reg       <= 4'h0;
      sep_cnt_reg   <= 8'h00;
      sep_reg       <= 1'b0;
      hs_prev_reg   <= 1'b0;
      vs_prev_reg   <= 1'b0;
      line_reg      <= 12'h000;
      total_reg     <= 12'h000;
      post_reg      <= 8'h00;
      pll_hsync_o   <= 1'b0;
      pll_hold_o    <= 1'b0;
      seek_mode_o   <= 1'b0;
      full_power_off_control_o   <= 1'b0;
      active_horizontal_source_o <= 1'b0;
      active_vertical_source_o   <= 1'b0;
    end
    else
    begin
      mode_reg      <= mode_next;
      hold_reg      <= hold_next;
      slice_reg     <= slice_next;
      sep_thr_reg   <= sep_thr_next;
      lead_reg      <= lead_next;
      trail_reg     <= trail_next;
      reg_rdata_o   <= rdata_next;
      div_reg       <= div_next;
      sep_cnt_reg   <= sep_cnt_next;
      sep_reg       <= sep_next;
      hs_prev_reg   <= hs_norm;
      vs_prev_reg   <= vs_norm;
      line_reg      <= line_next;
      total_reg     <= total_next;
      post_reg      <= post_next;
      pll_hsync_o   <= pll_hs_next;
      pll_hold_o    <= pll_hold_next;
      seek_mode_o   <= seek_next;
      full_power_off_control_o   <= !hold_next.power_on;                 // [R06]
      active_horizontal_source_o <= active_horizontal_source;
      active_vertical_source_o   <= active_vertical_source;
    end
  end

  // controls straight from their registers
  assign slicer_code_o            = slice_reg.slicer_code;               // [R07]
  assign clamp_mid_o              = slice_reg.clamp_mid;                 // [R08]
  assign sep_vsync_o              = sep_reg;

endmodule : sspc_top

// ==== logic/sspc_consts.svh ====
// constants for the sync source and pll hold control block
//
// Contract
// R01 - hold source: pin, or chosen vertical sync
// R02 - hold polarity automatic unless override bit set
// R03 - user polarity acts only with override set
// R04 - hold active level ignores hsync at pll
// R05 - seek allowed only when enabled and syncs idle
// R06 - power bit zero means full power-down
// R07 - slicer threshold code, inverse, reset 23
// R08 - per-channel clamp reference ground or midscale
// R09 - separator counts 5 MHz ticks to threshold
// R10 - software sets threshold above hsync width
// R11 - pre-hold asserts lines before vsync
// R12 - post-hold extends lines after vsync
// R13 - hsync activity status bit 7
// R14 - active horizontal source resolution and status
// R15 - detected hsync polarity status bit 5
// R16 - vsync activity status bit 4
// R17 - active vertical source resolution and status
// R18 - horizontal override and select bits
// R19 - vertical override and select bits
// R20 - status register read-only, writes ignored
`ifndef SSPC_CONSTS_SVH
`define SSPC_CONSTS_SVH

// register offsets
`define SSPC_MODE_OFS       8'h0E
`define SSPC_HOLD_OFS       8'h0F
`define SSPC_SLICE_OFS      8'h10
`define SSPC_SEP_OFS        8'h11
`define SSPC_LEAD_OFS       8'h12
`define SSPC_TRAIL_OFS      8'h13
`define SSPC_STAT_OFS       8'h14

// reset values
`define SSPC_MODE_RST       8'h40
`define SSPC_HOLD_RST       8'h4E
`define SSPC_SLICE_RST      8'hB8
`define SSPC_SEP_RST        8'h20
`define SSPC_LEAD_RST       8'h00
`define SSPC_TRAIL_RST      8'h00

// timing: 40 MHz system clock, 5 MHz separator tick
`define SSPC_CLK_HZ         40000000
`define SSPC_SEP_HZ         5000000
`define SSPC_SEP_DIV        (`SSPC_CLK_HZ / `SSPC_SEP_HZ)
// activity window in microseconds and in clock cycles
`define SSPC_ACT_WIN_US     50000
`define SSPC_ACT_WIN_CYC    (`SSPC_ACT_WIN_US * (`SSPC_CLK_HZ / 1000000))

`endif

// ==== logic/sspc_pkg.sv ====
// types shared by the sync source and pll hold control block
package sspc_pkg;

  // mode register fields, msb first
  typedef struct packed {
    logic hs_pol_ovr;
    logic hs_pol;
    logic hs_out_pol;
    logic hsrc_ovr;
    logic hsrc_sel;
    logic vs_out_inv;
    logic vsrc_ovr;
    logic vsrc_sel;
  } sspc_mode_t;

  // hold and power register fields, msb first
  typedef struct packed {
    logic clamp_ext;
    logic clamp_pol;
    logic hold_from_vs;
    logic hold_pol_ovr;
    logic hold_pol;
    logic seek_allow;
    logic power_on;
    logic spare;
  } sspc_hold_t;

  // slicer threshold and clamp references
  typedef struct packed {
    logic [4:0] slicer_code;
    logic [2:0] clamp_mid;
  } sspc_slice_t;

  // status register fields, msb first
  typedef struct packed {
    logic hs_det;
    logic active_horizontal_source;
    logic hs_pol;
    logic vs_det;
    logic active_vertical_source;
    logic vs_out_pol;
    logic gs_det;
    logic hold_pol;
  } sspc_stat_t;

  // what a pin watcher reports
  typedef struct packed {
    logic level;
    logic active;
    logic polarity;
  } sspc_watch_t;

endpackage : sspc_pkg

// ==== logic/sspc_sync_watch.sv ====
// pin synchroniser with activity and polarity detection
`timescale 1ns/1ps
module sspc_sync_watch
  import sspc_pkg::*;
#(
  parameter int unsigned WIN_CYC = 2000000
)
(
  // clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // raw pin
  input  wire logic        pin_i,
  // filtered state
  output sspc_watch_t      watch_o
);

  localparam int CW = $clog2(WIN_CYC + 1);

  logic [2:0]  sync_reg;         // three-stage synchroniser
  logic        lvl_reg;          // accepted level
  logic        lvl_next;
  logic        act_reg;          // transitions seen recently
  logic        act_next;
  logic        pol_reg;          // 1 = pulses are high
  logic        pol_next;
  logic [CW-1:0] idle_reg;       // cycles since last transition
  logic [CW-1:0] idle_next;
  logic [20:0] hi_reg;           // length of last high phase
  logic [20:0] hi_next;
  logic [20:0] lo_reg;           // length of last low phase
  logic [20:0] lo_next;
  logic        toggle;           // accepted change this cycle

  // a change counts once stages two and three agree
  always_comb
  begin
    toggle    = (sync_reg[1] == sync_reg[2]) && (sync_reg[2] != lvl_reg);
    lvl_next  = toggle ? sync_reg[2] : lvl_reg;
    act_next  = act_reg;
    idle_next = idle_reg;
    pol_next  = pol_reg;
    hi_next   = hi_reg;
    lo_next   = lo_reg;
    if (toggle)
    begin
      // any edge restarts the idle window
      idle_next = '0;
      act_next  = 1'b1;
    end
    else if (idle_reg == CW'(WIN_CYC - 1))
    begin
      // stuck high or low for the whole window
      act_next  = 1'b0;
    end
    else
    begin
      idle_next = idle_reg + 1'b1;
    end
    // the shorter phase is the pulse; saturating so long frames still compare
    if (toggle && sync_reg[2])
    begin
      pol_next = hi_reg < lo_reg;
      hi_next  = '0;
    end
    else if (toggle)
    begin
      lo_next  = '0;
    end
    else if (lvl_reg && !(&hi_reg))
    begin
      hi_next  = hi_reg + 1'b1;
    end
    else if (!lvl_reg && !(&lo_reg))
    begin
      lo_next  = lo_reg + 1'b1;
    end
  end

  // register stage
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_reg <= 3'h0;
      lvl_reg  <= 1'b0;
      act_reg  <= 1'b0;
      pol_reg  <= 1'b0;
      idle_reg <= '0;
      hi_reg   <= '0;
      lo_reg   <= '0;
    end
    else
    begin
      sync_reg <= {sync_reg[1:0], pin_i};
      lvl_reg  <= lvl_next;
      act_reg  <= act_next;
      pol_reg  <= pol_next;
      idle_reg <= idle_next;
      hi_reg   <= hi_next;
      lo_reg   <= lo_next;
    end
  end

  assign watch_o = '{level: lvl_reg, active: act_reg, polarity: pol_reg};

endmodule : sspc_sync_watch

// ==== bench/sspc_top_chk.sv ====
// port assertions for the sync source and pll hold control block
`timescale 1ns/1ps
module sspc_top_chk
  import sspc_pkg::*;
#(
  parameter int unsigned ACT_WIN_CYC = 2000
)
(
  // clock and reset
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // pll and front end outputs
  input wire logic       pll_hsync_o,
  input wire logic       pll_hold_o,
  input wire logic       sep_vsync_o,
  input wire logic [4:0] slicer_code_o,
  input wire logic [2:0] clamp_mid_o,
  input wire logic       full_power_off_control_o,
  input wire logic       seek_mode_o,
  input wire logic       active_horizontal_source_o,
  input wire logic       active_vertical_source_o
);
  // one clock domain, so one default clock and disable
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  // control bits reach their outputs one edge after the strobe, checked at the second
  chk_power_ctl: assert property (
    (reg_wr_i && reg_addr_i == 8'h0F) |-> ##2
    (full_power_off_control_o == (($past(reg_wdata_i, 2) & 8'h02) == 8'h00)))
    else $error("power-down output does not follow its bit");
  chk_slicer_clamp: assert property (
    (reg_wr_i && reg_addr_i == 8'h10) |-> ##2 ({slicer_code_o, clamp_mid_o} == $past(reg_wdata_i, 2)))
    else $error("slicer or clamp outputs do not follow the write");
  // a written byte reads back once the address has stood a cycle
  chk_read_back: assert property (
    (reg_wr_i && reg_addr_i >= 8'h0E && reg_addr_i <= 8'h13) ##1 (!reg_wr_i && $stable(reg_addr_i))
    |=> (reg_rdata_o == $past(reg_wdata_i, 2)))
    else $error("read data differs from the byte written");
  // status and unmapped writes must leave the slicer, clamp and power controls untouched
  chk_status_ro: assert property (
    (reg_wr_i && (reg_addr_i < 8'h0E || reg_addr_i > 8'h13))
    |=> $stable({slicer_code_o, clamp_mid_o, full_power_off_control_o}) [*3])
    else $error("write to status or unmapped place changed a control");
  chk_seek_block: assert property (
    (reg_wr_i && reg_addr_i == 8'h0F && reg_wdata_i[2:1] != 2'b11) |-> ##3 !seek_mode_o)
    else $error("seek mode entered while not allowed");
  chk_hsrc_override: assert property (
    (reg_wr_i && reg_addr_i == 8'h0E && reg_wdata_i[4])
    |-> ##3 (active_horizontal_source_o == (($past(reg_wdata_i, 3) & 8'h08) != 8'h00)))
    else $error("horizontal source ignores its override");
  chk_vsrc_override: assert property (
    (reg_wr_i && reg_addr_i == 8'h0E && reg_wdata_i[1])
    |-> ##3 (active_vertical_source_o == (($past(reg_wdata_i, 3) & 8'h01) != 8'h00)))
    else $error("vertical source ignores its override");
  // the separator moves only on its 5 MHz tick, eight cycles apart
  chk_sep_tick: assert property (
    $changed(sep_vsync_o) |=> $stable(sep_vsync_o) [*7])
    else $error("separator output changed between ticks");
  // a settled hold keeps hsync away from the pll
  chk_hold_mask: assert property (
    (pll_hold_o && $past(pll_hold_o)) |-> !pll_hsync_o)
    else $error("hsync passed to the pll during hold");
  chk_reset_vals: assert property (
    $rose(rst_n_i) |-> (slicer_code_o == 5'h17 && clamp_mid_o == 3'h0 && !full_power_off_control_o))
    else $error("front end outputs wrong after reset");
endmodule : sspc_top_chk

bind sspc_top sspc_top_chk #(.ACT_WIN_CYC(ACT_WIN_CYC)) u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .pll_hsync_o(pll_hsync_o),
  .pll_hold_o(pll_hold_o), .sep_vsync_o(sep_vsync_o), .slicer_code_o(slicer_code_o),
  .clamp_mid_o(clamp_mid_o), .full_power_off_control_o(full_power_off_control_o),
  .seek_mode_o(seek_mode_o), .active_horizontal_source_o(active_horizontal_source_o),
  .active_vertical_source_o(active_vertical_source_o));

// ==== bench/sspc_video_src.sv ====
// video source model: hsync, vsync, green sync and hold pins
`timescale 1ns/1ps
module sspc_video_src
#(
  parameter int unsigned HS_W   = 8,
  parameter int unsigned VS_OFS = 32
)
(
  // clock borrowed from the bench as pixel timebase
  input  wire logic mclk_i,
  // stream enables and hold level
  input  wire logic hs_en_i,
  input  wire logic vs_en_i,
  input  wire logic gs_en_i,
  input  wire logic hold_lvl_i,
  // pins towards the block
  output logic      hsync_o,
  output logic      vsync_o,
  output logic      gs_o,
  output logic      hold_o
);
  logic [8:0] pos_reg = 9'h000; // 8 lines of 64 cycles
  initial {hsync_o, vsync_o, gs_o, hold_o} = 4'h0;
  // stopped streams sit low so they never fake an edge
  always @(posedge mclk_i)
  begin
    pos_reg <= pos_reg + 9'h001;
    hsync_o <= hs_en_i && (pos_reg[5:0] < 6'(HS_W));
    gs_o    <= gs_en_i && (pos_reg[5:0] >= 6'(HS_W));
    vsync_o <= vs_en_i && (pos_reg >= 9'(VS_OFS)) && (pos_reg < 9'(VS_OFS + 128));
    hold_o  <= hold_lvl_i;
  end
endmodule : sspc_video_src

// ==== bench/sspc_top_tb_top.sv ====
// self-checking bench for the sync source and pll hold control block
`timescale 1ns/1ps
module sspc_top_tb_top;
  localparam int unsigned WIN = 1000; // short activity window
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic        reg_wr_i = 1'b0;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        hs_en = 1'b0, vs_en = 1'b0, gs_en = 1'b0, hold_lvl = 1'b0;
  logic        hs_pin, vs_pin, gs_pin, hold_pin;
  logic [7:0]  reg_rdata_o;
  logic        pll_hold_o, seek_mode_o, pwr_off;
  logic [4:0]  slicer_code_o;
  logic [2:0]  clamp_mid_o;
  logic [18:0] obs;          // rdata, hold, seek, slicer, clamp, power
  logic [37:0] notes[$];     // mask and expected value
  logic [37:0] n_note;
  logic [31:0] rnd = 32'h0000_25AF; // seed 9647
  int          n_errors = 0;
  int          n_checks = 0;
  assign obs = {reg_rdata_o, pll_hold_o, seek_mode_o, slicer_code_o, clamp_mid_o, pwr_off};

  initial forever #12.5 mclk_i = ~mclk_i;

  sspc_top #(.ACT_WIN_CYC(WIN)) u_dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsync_pin_i(hs_pin), .vsync_pin_i(vs_pin),
    .green_embedded_sync_input_i(gs_pin), .hold_pin_i(hold_pin), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .pll_hsync_o(), .pll_hold_o(pll_hold_o), .sep_vsync_o(), .slicer_code_o(slicer_code_o),
    .clamp_mid_o(clamp_mid_o), .full_power_off_control_o(pwr_off), .seek_mode_o(seek_mode_o),
    .active_horizontal_source_o(), .active_vertical_source_o());
  sspc_video_src u_src (
    .mclk_i(mclk_i), .hs_en_i(hs_en), .vs_en_i(vs_en), .gs_en_i(gs_en), .hold_lvl_i(hold_lvl),
    .hsync_o(hs_pin), .vsync_o(vs_pin), .gs_o(gs_pin), .hold_o(hold_pin));

  // inputs always move 1 ns after the edge
  task automatic tick(input int n = 1);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // the monitor takes this note at the next edge
  task automatic note(input logic [18:0] m, input logic [18:0] e);
    notes.push_back({m, e});
    tick();
  endtask : note
  // gap of three idle cycles lets each write settle at the outputs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick();
    reg_wr_i = 1'b0;
    tick(3);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    reg_addr_i = a;
    tick();
    note({m, 11'h000}, {e & m, 11'h000});
  endtask : rd
  task automatic hold_is(input logic h);
    tick(10);
    note(19'h0_0400, {8'h00, h, 10'h000});
  endtask : hold_is
  // hold cycles over one whole frame, after two frames to settle
  task automatic hold_len(output int len);
    len = 0;
    tick(1100);
    repeat (512)
    begin
      tick();
      len += (pll_hold_o === 1'b1) ? 1 : 0;
    end
  endtask : hold_len
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // compares the oldest note with the outputs
  always @(posedge mclk_i)
  begin
    if (notes.size() != 0)
    begin
      n_note = notes.pop_front();
      check(obs & n_note[37:19], n_note[18:0]);
    end
  end

  initial
  begin
    int d0, d1;
    logic [7:0] d;
    tick(2);
    rst_n_i = 1'b1;
    // reset values, idle status, seek and power-down
    rd(8'h0E, 8'h40);
    rd(8'h0F, 8'h4E);
    rd(8'h10, 8'hB8);
    rd(8'h11, 8'h20);
    rd(8'h12, 8'h00);
    rd(8'h13, 8'h00);
    rd(8'h3C, 8'h00);
    note(19'h0_01FF, {10'h000, 5'h17, 3'h0, 1'b0});
    rd(8'h14, 8'h08, 8'hDA);
    note(19'h0_0200, 19'h0_0200);
    wr(8'h0F, 8'h4C);
    note(19'h0_0201, 19'h0_0001);
    wr(8'h0F, 8'h4E);
    $display("reset test done");
    // hold from the pin; auto polarity ignores the programmed bit
    hold_is(1'b1);
    wr(8'h0F, 8'h46);
    hold_is(1'b1);
    wr(8'h0F, 8'h5E);
    hold_is(1'b0);
    hold_lvl = 1'b1;
    hold_is(1'b1);
    wr(8'h0F, 8'h56);
    hold_is(1'b0);
    hold_lvl = 1'b0;
    $display("hold pin test done");
    // activity, polarity and source choice, then overrides
    hs_en = 1'b1;
    vs_en = 1'b1;
    tick(1200);
    rd(8'h14, 8'hB0, 8'hFA);
    note(19'h0_0200, 19'h0_0000);
    hs_en = 1'b0;
    vs_en = 1'b0;
    gs_en = 1'b1;
    tick(WIN + 500);
    rd(8'h14, 8'h4A, 8'hDA);
    wr(8'h0E, 8'h52);
    rd(8'h14, 8'h00, 8'h48);
    wr(8'h0E, 8'h40);
    $display("detect test done");
    // hold from vsync, stretched by lead and trail lines
    gs_en = 1'b0;
    hs_en = 1'b1;
    vs_en = 1'b1;
    wr(8'h11, 8'h04);
    wr(8'h0F, 8'h6E);
    hold_len(d0);
    check(19'(d0 > 120 && d0 < 136), 19'h1);
    wr(8'h13, 8'h03);
    hold_len(d1);
    check(19'(d1 - d0 > 120 && d1 - d0 < 256), 19'h1);
    wr(8'h13, 8'h00);
    wr(8'h12, 8'h02);
    hold_len(d1);
    check(19'(d1 - d0 > 56 && d1 - d0 < 256), 19'h1);
    $display("lead trail test done");
    // random bytes through every control register but the mode register
    repeat (2)
    begin
      for (int a = 8'h0F; a <= 8'h13; a++)
      begin
        rnd = xs(rnd);
        d = rnd[7:0];
        wr(8'(a), d);
        rd(8'(a), d);
        if (a == 8'h0F)
          note(19'h0_0001, {18'h0_0000, !d[1]});
        if (a == 8'h10)
          note(19'h0_01FE, {10'h000, d, 1'b0});
      end
    end
    wr(8'h14, 8'h00);
    rd(8'h14, 8'hB0, 8'hFA);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, 8'h00);
    $display("register test done");
    results();
  end

  // cuts a hang well beyond the expected run length
  initial
  begin
    #1000000;
    n_errors++;
    results();
  end
endmodule : sspc_top_tb_top
